// ### design/hub_port_power_config_regs.sv
`timescale 1ns/10ps
// Summary of operation
// - Power source bit: 0 bus, 1 self
// - Dynamic mode takes power from sense pin
// - Bit six reports LED indicators present
// - Bit five forces full-speed-only attach
// - Bit four selects per-port translators
// - Bit three suppresses full-speed frame-end packet
// - Bits 2:1 pick over-current sensing mode
// - Bit zero selects per-port power switching
// - Dynamic bit allows automatic power fallback
// - Bits 5:4 choose over-current delay
// - Bit three reports compound device
// - Fixed-port bits 1-3 mark non-removable ports
// - Fixed-port bit zero reads zero
// - Self-powered port disable bits 1-3
// - Release id from bytes 05h and 06h
// - Reset clears every register to zero, except the over-current delay count, which loads the 100 us count
// - Lock bit blocks writes 01h-10h until reset
module hub_port_power_config_regs
    import hub_cfg_pkg::*;
#(
    parameter int DELAY_CYC_W = 24   // Width of over-current delay count
)
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire cfg_req_t         req,
    output logic [7:0]            rdata,
    output logic                  rvalid,
    output logic                  write_refused,
    input  wire logic             local_power_sense_pin,
    output hub_cfg_t              cfg,
    output logic [DELAY_CYC_W-1:0] overload_delay_cycles
);

    // Delay counts in cycles, derived from microseconds and clock rate
    localparam logic [DELAY_CYC_W-1:0] DELAY0_CYC = DELAY_CYC_W'(DELAY0_US * CLK_MHZ);
    localparam logic [DELAY_CYC_W-1:0] DELAY1_CYC = DELAY_CYC_W'(DELAY1_US * CLK_MHZ);
    localparam logic [DELAY_CYC_W-1:0] DELAY2_CYC = DELAY_CYC_W'(DELAY2_US * CLK_MHZ);
    localparam logic [DELAY_CYC_W-1:0] DELAY3_CYC = DELAY_CYC_W'(DELAY3_US * CLK_MHZ);

    logic [7:0] release_low_reg;    // Device release low byte
    logic [7:0] release_high_reg;   // Device release high byte
    logic [7:0] feature_a_reg;      // First feature byte
    logic [7:0] feature_b_reg;      // Second feature byte
    logic [7:0] fixed_ports_reg;    // Non-removable port mask
    logic [7:0] sp_off_reg;         // Self-powered port disable mask
    logic       config_lock_reg;    // Write-once lock
    logic       local_power;        // Synchronised sense pin
    logic       in_prot_range;      // Write targets locked range
    logic       wr_ok;              // Write allowed this cycle
    logic       self_powered;       // Effective power source
    logic [7:0] rd_mux;             // Read data before the output flop

    // Sense pin comes from outside, so it is filtered first
    sense_sync u_sense_sync
    (
        .clk   (clk),
        .nrst  (nrst),
        .pin   (local_power_sense_pin),
        .level (local_power)
    );

    // Address window guarded by the lock
    assign in_prot_range = (req.addr >= ADDR_PROT_LO) && (req.addr <= ADDR_PROT_HI);
    assign wr_ok         = req.wr && !(config_lock_reg && in_prot_range);

    // Lock is write-once; only the reset pin clears it
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            config_lock_reg <= 1'b0;
        else if (req.wr && req.addr == ADDR_STATUS_CMD && req.wdata[CMD_LOCK])
            config_lock_reg <= 1'b1;
    end

    // Device release bytes
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            release_low_reg  <= REG_RESET;
            release_high_reg <= REG_RESET;
        end
        else if (wr_ok)
        begin
            if (req.addr == ADDR_RELEASE_LOW)
                release_low_reg <= req.wdata;
            if (req.addr == ADDR_RELEASE_HIGH)
                release_high_reg <= req.wdata;
        end
    end

    // Feature bytes; reserved bits of the second byte never store
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            feature_a_reg <= REG_RESET;
            feature_b_reg <= REG_RESET;
        end
        else if (wr_ok)
        begin
            if (req.addr == ADDR_FEATURE_A)
                feature_a_reg <= req.wdata;
            if (req.addr == ADDR_FEATURE_B)
                feature_b_reg <= req.wdata & B_WRITE_MASK;
        end
    end

    // Port masks; bit 0 and upper reserved bits stay zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fixed_ports_reg <= REG_RESET;
            sp_off_reg      <= REG_RESET;
        end
        else if (wr_ok)
        begin
            if (req.addr == ADDR_FIXED_PORTS)
                fixed_ports_reg <= req.wdata & PORT_WRITE_MASK;
            if (req.addr == ADDR_SP_PORT_OFF)
                sp_off_reg <= req.wdata & PORT_WRITE_MASK;
        end
    end

    // Effective power source: pin in dynamic mode, stored bit otherwise
    always_comb
    begin
        if (feature_b_reg[B_DYNAMIC])
            self_powered = local_power;
        else
            self_powered = feature_a_reg[A_POWER_SRC];
    end

    // Read mux; unmapped indices read zero
    always_comb
    begin
        unique case (req.addr)
            ADDR_STATUS_CMD:   rd_mux = {6'h00, config_lock_reg, 1'b0};
            ADDR_RELEASE_LOW:  rd_mux = release_low_reg;
            ADDR_RELEASE_HIGH: rd_mux = release_high_reg;
            ADDR_FEATURE_A:    rd_mux = feature_a_reg;
            ADDR_FEATURE_B:    rd_mux = feature_b_reg;
            ADDR_FIXED_PORTS:  rd_mux = fixed_ports_reg;
            ADDR_SP_PORT_OFF:  rd_mux = sp_off_reg;
            default:           rd_mux = 8'h00;
        endcase
    end

    // Registered read answer, one cycle after the request
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= req.rd;
            rdata  <= req.rd ? rd_mux : 8'h00;
        end
    end

    // Pulse when a locked write is dropped
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            write_refused <= 1'b0;
        else
            write_refused <= req.wr && config_lock_reg && in_prot_range;
    end

    // Decoded configuration, registered for the hub core
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cfg <= '0;
        else
        begin
            cfg.self_powered              <= self_powered;
            cfg.led_indicator_present     <= feature_a_reg[A_LED];
            cfg.full_speed_only           <= feature_a_reg[A_FS_ONLY];
            cfg.per_port_translator_en    <= feature_a_reg[A_MTT];
            cfg.frame_end_packet_suppress <= feature_a_reg[A_EOP_SUP];
            // No-sensing is legal only with bus power; host keeps that
            if (feature_a_reg[A_SENSE_HI])
                cfg.overload_sense_mode <= SENSE_NONE;
            else if (feature_a_reg[A_SENSE_LO])
                cfg.overload_sense_mode <= SENSE_PER_PORT;
            else
                cfg.overload_sense_mode <= SENSE_GANGED;
            cfg.per_port_power_switching  <= feature_a_reg[A_PER_PORT_POWER_SWITCHING];
            cfg.dynamic_switching         <= feature_b_reg[B_DYNAMIC];
            cfg.compound_device           <= feature_b_reg[B_COMPOUND];
            cfg.fixed_port_mask           <= fixed_ports_reg[3:1];
            // Disable mask applies only while self-powered
            cfg.port_disabled             <= self_powered ? sp_off_reg[3:1] : 3'b000;
            cfg.device_release            <= {release_high_reg, release_low_reg};
        end
    end

    // Over-current delay count from the two select bits
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            overload_delay_cycles <= DELAY0_CYC;
        else
        begin
            unique case (feature_b_reg[B_DELAY_HI:B_DELAY_LO])
                2'b00: overload_delay_cycles <= DELAY0_CYC;
                2'b01: overload_delay_cycles <= DELAY1_CYC;
                2'b10: overload_delay_cycles <= DELAY2_CYC;
                2'b11: overload_delay_cycles <= DELAY3_CYC;
            endcase
        end
    end

endmodule // hub_port_power_config_regs

// ### shared/hub_cfg_pkg.sv
package hub_cfg_pkg;

    // Register indices on the byte-wide configuration port
    localparam logic [7:0] ADDR_STATUS_CMD      = 8'h00;
    localparam logic [7:0] ADDR_PROT_LO         = 8'h01;
    localparam logic [7:0] ADDR_PROT_HI         = 8'h10;
    localparam logic [7:0] ADDR_RELEASE_LOW     = 8'h05;
    localparam logic [7:0] ADDR_RELEASE_HIGH    = 8'h06;
    localparam logic [7:0] ADDR_FEATURE_A       = 8'h07;
    localparam logic [7:0] ADDR_FEATURE_B       = 8'h08;
    localparam logic [7:0] ADDR_FIXED_PORTS     = 8'h09;
    localparam logic [7:0] ADDR_SP_PORT_OFF     = 8'h0A;

    // Reset value of every stored configuration byte
    localparam logic [7:0] REG_RESET            = 8'h00;

    // Field positions, first feature byte
    localparam int A_POWER_SRC   = 7;
    localparam int A_LED         = 6;
    localparam int A_FS_ONLY     = 5;
    localparam int A_MTT         = 4;
    localparam int A_EOP_SUP     = 3;
    localparam int A_SENSE_HI    = 2;
    localparam int A_SENSE_LO    = 1;
    localparam int A_PER_PORT_POWER_SWITCHING    = 0;

    // Field positions, second feature byte
    localparam int B_DYNAMIC     = 7;
    localparam int B_DELAY_HI    = 5;
    localparam int B_DELAY_LO    = 4;
    localparam int B_COMPOUND    = 3;

    // Writable bits of the second byte and the port masks
    localparam logic [7:0] B_WRITE_MASK         = 8'hB8;
    localparam logic [7:0] PORT_WRITE_MASK      = 8'h0E;

    // Status/command lock bit position
    localparam int CMD_LOCK      = 1;

    // Over-current sensing modes
    typedef enum logic [1:0] {
        SENSE_GANGED     = 2'b00,
        SENSE_PER_PORT   = 2'b01,
        SENSE_NONE       = 2'b10
    } sense_mode_t;

    // Over-current delay times in microseconds, and clock rate
    localparam int CLK_MHZ       = 250;
    localparam int DELAY0_US     = 100;
    localparam int DELAY1_US     = 2000;
    localparam int DELAY2_US     = 4000;
    localparam int DELAY3_US     = 6000;

    // Byte access on the configuration port
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cfg_req_t;

    // Decoded hub configuration
    typedef struct packed {
        logic        self_powered;
        logic        led_indicator_present;
        logic        full_speed_only;
        logic        per_port_translator_en;
        logic        frame_end_packet_suppress;
        sense_mode_t overload_sense_mode;
        logic        per_port_power_switching;
        logic        dynamic_switching;
        logic        compound_device;
        logic [2:0]  fixed_port_mask;
        logic [2:0]  port_disabled;
        logic [15:0] device_release;
    } hub_cfg_t;

endpackage

// ### design/sense_sync.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser; output moves once stages two and three agree
module sense_sync
    import hub_cfg_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level
);

    logic meta_reg;      // First stage, read only by the second
    logic s2_reg;        // Second stage
    logic s3_reg;        // Third stage

    // Shift chain
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_reg <= 1'b0;
            s2_reg   <= 1'b0;
            s3_reg   <= 1'b0;
        end
        else
        begin
            meta_reg <= pin;
            s2_reg   <= meta_reg;
            s3_reg   <= s2_reg;
        end
    end

    // Filtered level holds until two late stages agree
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            level <= 1'b0;
        else if (s2_reg == s3_reg)
            level <= s3_reg;
    end

endmodule // sense_sync

// ### sim/hub_cfg_monitor.sv
`timescale 1ns/10ps
// Port-level checks of the configuration register block
module hub_cfg_monitor
    import hub_cfg_pkg::*;
#(
    parameter int DELAY_CYC_W = 24 // Width of delay count
)
(
    input wire logic                   clk,
    input wire logic                   nrst,
    input wire cfg_req_t               req,
    input wire logic [7:0]             rdata,
    input wire logic                   rvalid,
    input wire logic                   write_refused,
    input wire logic                   local_power_sense_pin,
    input wire hub_cfg_t               cfg,
    input wire logic [DELAY_CYC_W-1:0] overload_delay_cycles
);
    // One clock domain, so one default clock and reset
    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_READ_ANSWER: assert property (req.rd |=> rvalid)
        else $error("read request got no answer");
    AST_RESET_CLEAR: assert property ($rose(nrst) |-> cfg == '0 && overload_delay_cycles == 25000)
        else $error("outputs not cleared by reset");
    AST_FIXED_BIT0: assert property (rvalid && $past(req.addr) == ADDR_FIXED_PORTS |-> !rdata[0])
        else $error("fixed port bit zero read as one");
    AST_SPOFF_BIT0: assert property (rvalid && $past(req.addr) == ADDR_SP_PORT_OFF |-> !rdata[0])
        else $error("port disable bit zero read as one");
    AST_B_RESERVED: assert property (rvalid && $past(req.addr) == ADDR_FEATURE_B |->
        (rdata & ~B_WRITE_MASK) == 8'h00) else $error("reserved bits of second byte not zero");
    // Write accepted, then decode lands one edge after the stored byte
    AST_SELF_FOLLOWS: assert property ((req.wr && req.addr == ADDR_FEATURE_A && !cfg.dynamic_switching)
        ##1 !write_refused |=> cfg.self_powered == $past(req.wdata[A_POWER_SRC], 2))
        else $error("power source does not follow stored bit");
    AST_FS_ONLY: assert property ((req.wr && req.addr == ADDR_FEATURE_A) ##1 !write_refused
        |=> cfg.full_speed_only == $past(req.wdata[A_FS_ONLY], 2)) else $error("speed limit wrong");
    AST_REFUSE_CAUSE: assert property (write_refused |-> $past(req.wr) &&
        $past(req.addr) inside {[ADDR_PROT_LO:ADDR_PROT_HI]}) else $error("refusal without locked write");
    AST_DELAY_SET: assert property (overload_delay_cycles inside {25000, 500000, 1000000, 1500000})
        else $error("delay count outside the four choices");
endmodule // hub_cfg_monitor

// ### sim/cfg_host_model.sv
`timescale 1ns/10ps
// Configuring host: byte accesses by register index, one request edge each
module cfg_host_model
    import hub_cfg_pkg::*;
(
    input wire logic       clk,
    input wire logic [7:0] rdata,
    input wire logic       rvalid,
    output cfg_req_t       req
);
    // Idle bus carries no request
    initial req = '0;

    // Byte write; held until the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(posedge clk);
        req <= '0;
    endtask

    // Byte read; answer taken at the edge where it stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
        v = rvalid;
        d = rdata;
    endtask
endmodule // cfg_host_model

// ### sim/hub_port_power_config_regs_bench.sv
`timescale 1ns/10ps
module hub_port_power_config_regs_bench;
    import hub_cfg_pkg::*;
    logic       clk, nrst, sense, rvalid, refused, v;
    logic [7:0] rdata, d;
    cfg_req_t   req;
    hub_cfg_t   cfg;
    logic [23:0] dly;
    int         num_errors, n_tests;

    hub_port_power_config_regs hub_port_power_config_regs_i (.clk(clk), .nrst(nrst), .req(req), .rdata(rdata),
        .rvalid(rvalid), .write_refused(refused), .local_power_sense_pin(sense), .cfg(cfg),
        .overload_delay_cycles(dly));
    cfg_host_model cfg_host_model_i (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req));

    initial clk = 1'b0;
    always #2 clk = ~clk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    // Read and compare, answer flag included
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        cfg_host_model_i.rd(a, d, v);
        check({v, d}, {1'b1, e});
    endtask
    // Wait for stored byte and its decode
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic pulse_reset(input int n);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (n) @(posedge clk);
        nrst <= 1'b1;
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic t_reset_values();
        for (int a = 5; a <= 10; a++)
            rchk(8'(a), 8'h00);
        rchk(8'h20, 8'h00);
        check(cfg, 32'h0);
        check(dly, CLK_MHZ * DELAY0_US);
        $display("reset values done");
    endtask
    // Last two values use no sensing (10 and 11), only while bus-powered
    task automatic t_feature_a();
        logic [7:0] va[4] = '{8'h7B, 8'h80, 8'h04, 8'h06};
        foreach (va[i])
        begin
            cfg_host_model_i.wr(ADDR_FEATURE_A, va[i]);
            settle();
            check(cfg.self_powered, va[i][7]);
            check(cfg.led_indicator_present, va[i][6]);
            check(cfg.full_speed_only, va[i][5]);
            check(cfg.per_port_translator_en, va[i][4]);
            check(cfg.frame_end_packet_suppress, va[i][3]);
            check(cfg.overload_sense_mode, va[i][2] ? SENSE_NONE : va[i][1] ? SENSE_PER_PORT : SENSE_GANGED);
            check(cfg.per_port_power_switching, va[i][0]);
            rchk(ADDR_FEATURE_A, va[i]);
        end
        $display("first feature byte done");
    endtask
    task automatic t_feature_b();
        int us[4] = '{DELAY0_US, DELAY1_US, DELAY2_US, DELAY3_US};
        cfg_host_model_i.wr(ADDR_FEATURE_B, 8'hFF);
        rchk(ADDR_FEATURE_B, 8'hB8);
        for (int c = 0; c < 4; c++)
        begin
            cfg_host_model_i.wr(ADDR_FEATURE_B, {2'b00, 2'(c), 4'h8});
            settle();
            check(dly, us[c] * CLK_MHZ);
            check(cfg.compound_device, 1'b1);
            check(cfg.dynamic_switching, 1'b0);
        end
        $display("second feature byte done");
    endtask
    // Ports, release id, then disable mask cleared once the stored power bit selects bus power
    task automatic t_ports_release();
        cfg_host_model_i.wr(ADDR_FEATURE_A, 8'h80);
        cfg_host_model_i.wr(ADDR_FIXED_PORTS, 8'hFF);
        cfg_host_model_i.wr(ADDR_SP_PORT_OFF, 8'h0C);
        cfg_host_model_i.wr(ADDR_RELEASE_LOW, 8'h34);
        cfg_host_model_i.wr(ADDR_RELEASE_HIGH, 8'h12);
        settle();
        rchk(ADDR_FIXED_PORTS, 8'h0E);
        rchk(ADDR_SP_PORT_OFF, 8'h0C);
        check(cfg.fixed_port_mask, 3'b111);
        check(cfg.port_disabled, 3'b110);
        check(cfg.device_release, 16'h1234);
        cfg_host_model_i.wr(ADDR_FEATURE_A, 8'h00);
        settle();
        check(cfg.port_disabled, 3'b000);
        $display("ports and release done");
    endtask
    task automatic t_dynamic();
        cfg_host_model_i.wr(ADDR_FEATURE_B, 8'h80);
        @(posedge clk);
        sense <= 1'b1;
        repeat (10) @(posedge clk);
        check(cfg.self_powered, 1'b1);
        check(cfg.dynamic_switching, 1'b1);
        check(refused, 1'b0);
        check(rdata, 8'h00);
        sense <= 1'b0;
        repeat (10) @(posedge clk);
        check(cfg.self_powered, 1'b0);
        cfg_host_model_i.wr(ADDR_FEATURE_A, 8'h80);
        settle();
        check(cfg.self_powered, 1'b0);
        cfg_host_model_i.wr(ADDR_FEATURE_B, 8'h00);
        settle();
        check(cfg.self_powered, 1'b1);
        $display("dynamic switching done");
    endtask
    // Lock holds off writes until a fresh reset
    task automatic t_lock();
        cfg_host_model_i.wr(ADDR_STATUS_CMD, 8'h02);
        rchk(ADDR_STATUS_CMD, 8'h02);
        cfg_host_model_i.wr(ADDR_FEATURE_A, 8'h55);
        @(posedge clk);
        check(refused, 1'b1);
        rchk(ADDR_FEATURE_A, 8'h80);
        pulse_reset(2);
        rchk(ADDR_STATUS_CMD, 8'h00);
        rchk(ADDR_FEATURE_A, 8'h00);
        $display("lock done");
    endtask

    initial
    begin
        nrst = 1'b0;
        sense = 1'b0;
        num_errors = 0;
        n_tests = 0;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        t_reset_values();
        t_feature_a();
        t_feature_b();
        t_ports_release();
        t_dynamic();
        t_lock();
        complete_run();
    end
    // Run needs under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        complete_run();
    end
endmodule // hub_port_power_config_regs_bench

bind hub_port_power_config_regs hub_cfg_monitor #(.DELAY_CYC_W(DELAY_CYC_W)) hub_cfg_monitor_i (.clk(clk),
    .nrst(nrst), .req(req), .rdata(rdata), .rvalid(rvalid), .write_refused(write_refused),
    .local_power_sense_pin(local_power_sense_pin), .cfg(cfg), .overload_delay_cycles(overload_delay_cycles));
